// ===== pwm_pair_config_lock.sv
// configuration front end of a three-pair pwm generator
// assumes a synchronous byte register port and external counters
// assumes wr and rd are never high in the same cycle
`timescale 1ns/10ps
`include "pwm_cfg_defines.svh"

module pwm_pair_config_lock import pwm_cfg_pkg::*; #(
  parameter int ADDR_W = 16,
  parameter logic [15:0] BASE_ADDR = 16'h0000,
  parameter int COUNT_W = 15
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [COUNT_W-1:0] counter_a,
  input wire logic [COUNT_W-1:0] counter_b,
  input wire logic [COUNT_W-1:0] counter_c,
  output logic write_locked,
  output logic multi_timebase_select,
  output logic pair_a_edge_align,
  output logic pair_b_edge_align,
  output logic pair_c_edge_align,
  output logic pair_a_separate_mode,
  output logic pair_b_separate_mode,
  output logic pair_c_separate_mode,
  output logic accel_write_enable,
  output logic [5:0] channel_invert,
  output logic [1:0] value_load_mode,
  output logic pair_a_exchange,
  output logic pair_b_exchange,
  output logic pair_c_exchange,
  output logic stop_in_wait,
  output logic stop_in_freeze,
  output logic channel_0_out,
  output logic channel_1_out,
  output logic channel_2_out,
  output logic channel_3_out,
  output logic channel_4_out,
  output logic channel_5_out
);

  cfg_state_t s_reg;
  cfg_state_t s_next;
  logic [15:0] off;
  logic [5:0] chan_level;
  logic [5:0] region;
  logic cfg_open;
  logic accel_open;
  logic bc_open;

  // one-hot region select, shared by the read mux and the write path
  localparam int RG_GLOBAL = 0;
  localparam int RG_POL = 1;
  localparam int RG_ACCEL = 2;
  localparam int RG_VALUE = 3;
  localparam int RG_TB_A = 4;
  localparam int RG_TB_BC = 5;

  // =====================================================================
  // helpers
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // two byte offsets per value: high byte even, low byte odd
  function automatic logic [2:0] value_index(input logic [15:0] a);
    value_index = a[3:1];
  endfunction

  // generator a bytes first, then the b/c bytes
  function automatic logic [4:0] tb_index(input logic [15:0] a);
    tb_index = 5'(a - `OFF_TB_A_FIRST);
  endfunction

  // reserved load mode behaves as independent access
  function automatic logic copy_to(input logic [1:0] mode,
                                   input int k);
    unique case (mode)
      `VLM_INDEP: copy_to = 1'b0;
      `VLM_TO_FIVE: copy_to = 1'b1;
      `VLM_TO_THREE: copy_to = (k <= 3);
      2'h3: copy_to = 1'b0;
    endcase
  endfunction

  // at most one region bit is set for any offset
  function automatic logic [5:0] region_of(input logic [15:0] a);
    region_of = 6'h00;
    region_of[RG_GLOBAL] = (a == `OFF_GLOBAL_CFG);
    region_of[RG_POL] = (a == `OFF_POL_ACCEL_CFG);
    region_of[RG_ACCEL] = (a == `OFF_ACCEL_CFG);
    region_of[RG_VALUE] = in_range(a, `OFF_VALUE_FIRST, `OFF_VALUE_LAST);
    region_of[RG_TB_A] = in_range(a, `OFF_TB_A_FIRST, `OFF_TB_A_LAST);
    region_of[RG_TB_BC] = in_range(a, `OFF_TB_BC_FIRST, `OFF_TB_BC_LAST);
  endfunction

  function automatic logic [7:0] read_reg(input logic [15:0] a,
                                          input cfg_state_t st);
    logic [2:0] vi;
    logic [4:0] ti;
    logic [5:0] rg;
    vi = value_index(a);
    ti = tb_index(a);
    rg = region_of(a);
    // reserved bits, unmapped offsets and the hidden b/c bytes read zero
    read_reg = 8'h00;
    if (rg[RG_GLOBAL]) begin
      read_reg = {st.lock, st.multi, st.edge_sel, st.separate};
    end else if (rg[RG_POL]) begin
      read_reg = {st.accel, 1'b0, st.invert};
    end else if (rg[RG_ACCEL]) begin
      read_reg = {st.wait_off, st.freeze_off, 1'b0, st.vlm, st.exchange};
    end else if (rg[RG_VALUE]) begin
      read_reg = a[0] ? st.value[vi][7:0] : st.value[vi][15:8];
    end else if (rg[RG_TB_A]) begin
      read_reg = st.tb[ti];
    end else if (rg[RG_TB_BC]) begin
      read_reg = st.multi ? st.tb[ti] : 8'h00;
    end
  endfunction

  // =====================================================================
  // address decode
  always_comb begin
    off = 16'(addr - ADDR_W'(BASE_ADDR));
    region = region_of(off);
  end

  // =====================================================================
  // write permissions
  // lock and acceleration enable are used as registered, so a write that
  // sets the lock still lands its own lower bits; the b/c timebase bytes
  // exist only with several timebases
  always_comb begin
    cfg_open = !s_reg.lock;
    accel_open = s_reg.accel;
    bc_open = s_reg.multi;
  end

  // =====================================================================
  // output pairs
  // pairs b and c take their own counter only with several timebases
  for (genvar p = 0; p < 3; p++) begin : g_pair
    logic [COUNT_W-1:0] cnt;
    always_comb begin
      if (p == 0 || !s_reg.multi) begin
        cnt = counter_a;
      end else if (p == 1) begin
        cnt = counter_b;
      end else begin
        cnt = counter_c;
      end
    end
    pwm_pair_stage #(
      .COUNT_W(COUNT_W)
    ) u_stage (
      .counter(cnt),
      .width_top(s_reg.value[2*p]),
      .width_bot(s_reg.value[2*p+1]),
      .separate(s_reg.separate[p]),
      .exchange(s_reg.exchange[p]),
      .top_invert(s_reg.invert[2*p]),
      .bottom_invert(s_reg.invert[2*p+1]),
      .top_level(chan_level[2*p]),
      .bottom_level(chan_level[2*p+1])
    );
  end

  // =====================================================================
  // next state
  always_comb begin
    logic [2:0] vi;
    logic [4:0] ti;
    logic [15:0] word;
    vi = value_index(off);
    ti = tb_index(off);
    word = 16'h0000;
    s_next = s_reg;
    s_next.rdata = 8'h00;
    if (wr) begin
      if (region[RG_GLOBAL]) begin
        // lock and multi only ever set: a zero write must not reopen them
        if (wdata[`BIT_LOCK]) begin
          s_next.lock = 1'b1;
        end
        if (wdata[`BIT_MULTI]) begin
          s_next.multi = 1'b1;
        end
        if (cfg_open) begin
          s_next.edge_sel = wdata[`BIT_EDGE_C:`BIT_EDGE_A];
          s_next.separate = wdata[`BIT_SEP_C:`BIT_SEP_A];
        end
      end else if (region[RG_POL]) begin
        if (cfg_open) begin
          s_next.accel = wdata[`BIT_ACCEL];
          s_next.invert = wdata[`BIT_INV_HI:`BIT_INV_LO];
        end
      end else if (region[RG_ACCEL]) begin
        s_next.wait_off = wdata[`BIT_WAIT_OFF];
        s_next.freeze_off = wdata[`BIT_FREEZE_OFF];
        if (accel_open) begin
          s_next.vlm = wdata[`BIT_VLM_HI:`BIT_VLM_LO];
          s_next.exchange = wdata[`BIT_EXCH_HI:`BIT_EXCH_LO];
        end
      end else if (region[RG_VALUE]) begin
        // a byte write keeps the other byte of the value
        word = s_reg.value[vi];
        if (off[0]) begin
          word[7:0] = wdata;
        end else begin
          word[15:8] = wdata;
        end
        s_next.value[vi] = word;
        if (vi == 3'h0) begin
          for (int k = 1; k < 6; k++) begin
            if (copy_to(s_reg.vlm, k)) begin
              s_next.value[k] = word;
            end
          end
        end
      end else if (region[RG_TB_A]) begin
        s_next.tb[ti] = wdata;
      end else if (region[RG_TB_BC]) begin
        if (bc_open) begin
          s_next.tb[ti] = wdata;
        end
      end
    end
    if (rd) begin
      s_next.rdata = read_reg(off, s_reg);
    end
    // with one timebase pairs b and c follow pair a's alignment bit
    s_next.align_eff[0] = s_reg.edge_sel[0];
    s_next.align_eff[1] = s_reg.multi ? s_reg.edge_sel[1]
                                      : s_reg.edge_sel[0];
    s_next.align_eff[2] = s_reg.multi ? s_reg.edge_sel[2]
                                      : s_reg.edge_sel[0];
    s_next.chan = chan_level;
  end

  // =====================================================================
  // state register
  // ce low freezes every field, read data and channel levels included
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // =====================================================================
  // outputs
  assign rdata = s_reg.rdata;
  assign write_locked = s_reg.lock;
  assign multi_timebase_select = s_reg.multi;
  // edge align outputs lag the configuration bits by one more cycle
  assign pair_a_edge_align = s_reg.align_eff[0];
  assign pair_b_edge_align = s_reg.align_eff[1];
  assign pair_c_edge_align = s_reg.align_eff[2];
  assign pair_a_separate_mode = s_reg.separate[0];
  assign pair_b_separate_mode = s_reg.separate[1];
  assign pair_c_separate_mode = s_reg.separate[2];
  assign accel_write_enable = s_reg.accel;
  assign channel_invert = s_reg.invert;
  assign value_load_mode = s_reg.vlm;
  assign pair_a_exchange = s_reg.exchange[0];
  assign pair_b_exchange = s_reg.exchange[1];
  assign pair_c_exchange = s_reg.exchange[2];
  assign stop_in_wait = s_reg.wait_off;
  assign stop_in_freeze = s_reg.freeze_off;
  assign channel_0_out = s_reg.chan[0];
  assign channel_1_out = s_reg.chan[1];
  assign channel_2_out = s_reg.chan[2];
  assign channel_3_out = s_reg.chan[3];
  assign channel_4_out = s_reg.chan[4];
  assign channel_5_out = s_reg.chan[5];

endmodule // pwm_pair_config_lock

// ===== pwm_cfg_defines.svh
// register offsets, field positions and reset values of the pwm
// configuration front end; included by the package and the top module
`ifndef PWM_CFG_DEFINES_SVH
`define PWM_CFG_DEFINES_SVH

// =====================================================================
// module-level offsets (added to the chip-level base)
`define OFF_GLOBAL_CFG    16'h0000
`define OFF_POL_ACCEL_CFG 16'h0001
`define OFF_ACCEL_CFG     16'h0003
`define OFF_VALUE_FIRST   16'h0010
`define OFF_VALUE_LAST    16'h001b
`define OFF_TB_A_FIRST    16'h0020
`define OFF_TB_A_LAST     16'h0027
`define OFF_TB_BC_FIRST   16'h0028
`define OFF_TB_BC_LAST    16'h0037

// =====================================================================
// field positions of the global configuration register
`define BIT_LOCK          7
`define BIT_MULTI         6
`define BIT_EDGE_C        5
`define BIT_EDGE_A        3
`define BIT_SEP_C         2
`define BIT_SEP_A         0

// =====================================================================
// field positions of the polarity and acceleration register
`define BIT_ACCEL         7
`define BIT_INV_HI        5
`define BIT_INV_LO        0

// =====================================================================
// field positions of the acceleration-controlled register
`define BIT_WAIT_OFF      7
`define BIT_FREEZE_OFF    6
`define BIT_VLM_HI        4
`define BIT_VLM_LO        3
`define BIT_EXCH_HI       2
`define BIT_EXCH_LO       0

// =====================================================================
// value load modes and reset values
`define VLM_INDEP         2'h0
`define VLM_TO_FIVE       2'h1
`define VLM_TO_THREE      2'h2
`define RESET_CFG_BYTE    8'h00
`define TB_BYTES          24

`endif

// ===== pwm_cfg_pkg.sv
// types shared by the pwm configuration front end
// assumes pwm_cfg_defines.svh is on the include path
`include "pwm_cfg_defines.svh"

package pwm_cfg_pkg;

  // ===================================================================
  // whole state of the top module, registered as one word
  typedef struct packed {
    logic lock;
    logic multi;
    logic [2:0] edge_sel;
    logic [2:0] separate;
    logic accel;
    logic [5:0] invert;
    logic wait_off;
    logic freeze_off;
    logic [1:0] vlm;
    logic [2:0] exchange;
    logic [5:0][15:0] value;
    logic [`TB_BYTES-1:0][7:0] tb;
    logic [7:0] rdata;
    logic [2:0] align_eff;
    logic [5:0] chan;
  } cfg_state_t;

endpackage

// ===== pwm_pair_stage.sv
// one output pair: compare, pair mode, exchange and polarity
// assumes counter and pulse widths are stable in the clock domain
`timescale 1ns/10ps

module pwm_pair_stage #(
  parameter int COUNT_W = 15
) (
  input wire logic [COUNT_W-1:0] counter,
  input wire logic [15:0] width_top,
  input wire logic [15:0] width_bot,
  input wire logic separate,
  input wire logic exchange,
  input wire logic top_invert,
  input wire logic bottom_invert,
  output logic top_level,
  output logic bottom_level
);

  logic raw_top;
  logic raw_bot;
  logic sw_top;
  logic sw_bot;

  // =====================================================================
  // pair logic
  always_comb begin
    raw_top = {{(16-COUNT_W){1'b0}}, counter} <= width_top;
    raw_bot = separate ? ({{(16-COUNT_W){1'b0}}, counter} <= width_bot)
                       : ~raw_top;
    sw_top = raw_top;
    sw_bot = raw_bot;
    if (!separate && exchange) begin
      sw_top = raw_bot;
      sw_bot = raw_top;
    end
    top_level = sw_top ^ top_invert;
    bottom_level = sw_bot ^ bottom_invert;
  end

endmodule // pwm_pair_stage

// ===== pwm_cfg_props.sv
// assertions on the ports of the pwm configuration front end
// assumes it is bound to pwm_pair_config_lock; ce may drop at any time
`timescale 1ns/10ps

module pwm_cfg_props #(
  parameter logic [15:0] BASE_ADDR = 16'h0000
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic write_locked,
  input wire logic multi_timebase_select,
  input wire logic pair_a_edge_align,
  input wire logic pair_b_edge_align,
  input wire logic pair_c_edge_align,
  input wire logic pair_a_separate_mode,
  input wire logic pair_b_separate_mode,
  input wire logic pair_c_separate_mode,
  input wire logic accel_write_enable,
  input wire logic [5:0] channel_invert,
  input wire logic [1:0] value_load_mode,
  input wire logic pair_a_exchange,
  input wire logic pair_b_exchange,
  input wire logic pair_c_exchange,
  input wire logic channel_0_out,
  input wire logic channel_1_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ===================================================================
  // sticky bits and locking
  property p_lock; write_locked |=> write_locked; endproperty
  a_lock: assert property (p_lock) else $error("lock cleared");
  property p_multi;
    multi_timebase_select |=> multi_timebase_select;
  endproperty
  a_multi: assert property (p_multi) else $error("multi cleared");
  property p_sep;
    write_locked |=> $stable({pair_a_separate_mode, pair_b_separate_mode,
      pair_c_separate_mode});
  endproperty
  a_sep: assert property (p_sep) else $error("mode changed");
  property p_inv; write_locked |=> $stable(channel_invert); endproperty
  a_inv: assert property (p_inv) else $error("polarity changed");
  property p_accel;
    !accel_write_enable |=> $stable({value_load_mode, pair_a_exchange,
      pair_b_exchange, pair_c_exchange});
  endproperty
  a_accel: assert property (p_accel) else $error("accel field moved");
  // ===================================================================
  // read port, timebase and pair relations
  property p_rdz; (!rd && ce) |=> rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("rdata not idle");
  property p_bcz;
    (rd && ce && !multi_timebase_select &&
      (addr - BASE_ADDR) inside {[16'h0028:16'h0037]}) |=> rdata == 8'h00;
  endproperty
  a_bcz: assert property (p_bcz) else $error("b c range read");
  property p_align;
    !multi_timebase_select |-> pair_b_edge_align == pair_a_edge_align &&
      pair_c_edge_align == pair_a_edge_align;
  endproperty
  a_align: assert property (p_align) else $error("align split");
  property p_comp;
    (ce && !pair_a_separate_mode && channel_invert[1:0] == 2'h0) |=>
      channel_0_out != channel_1_out;
  endproperty
  a_comp: assert property (p_comp) else $error("pair not complement");
endmodule // pwm_cfg_props

bind pwm_pair_config_lock pwm_cfg_props #(.BASE_ADDR(BASE_ADDR)) props_inst (
  .clock, .nrst, .ce, .addr, .rd, .rdata, .write_locked,
  .multi_timebase_select, .pair_a_edge_align, .pair_b_edge_align,
  .pair_c_edge_align, .pair_a_separate_mode, .pair_b_separate_mode,
  .pair_c_separate_mode, .accel_write_enable, .channel_invert,
  .value_load_mode, .pair_a_exchange, .pair_b_exchange, .pair_c_exchange,
  .channel_0_out, .channel_1_out);

// ===== tb.sv
// self-checking bench of the pwm configuration front end
// assumes the design files and pwm_cfg_props.sv are compiled first
`timescale 1ns/10ps

module tb;
  localparam logic [15:0] BASE = 16'h0100;
  logic clock = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [14:0] cn [3] = '{default: 15'h0000};
  logic wl, mts, acc, siw, sif;
  logic [2:0] ed, sp, xc;
  logic [5:0] inv, ch;
  logic [1:0] vlm;
  logic [31:0] lf = 32'ha072e705;
  int g, p, c3, n_mismatch, n_tests;
  int v[6] = '{default: 0};
  int t[24] = '{default: 0};

  pwm_pair_config_lock #(.BASE_ADDR(BASE)) pwm_pair_config_lock_inst (
    .clock(clock), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .counter_a(cn[0]), .counter_b(cn[1]),
    .counter_c(cn[2]), .write_locked(wl), .multi_timebase_select(mts),
    .pair_a_edge_align(ed[0]), .pair_b_edge_align(ed[1]),
    .pair_c_edge_align(ed[2]), .pair_a_separate_mode(sp[0]),
    .pair_b_separate_mode(sp[1]), .pair_c_separate_mode(sp[2]),
    .accel_write_enable(acc), .channel_invert(inv), .value_load_mode(vlm),
    .pair_a_exchange(xc[0]), .pair_b_exchange(xc[1]),
    .pair_c_exchange(xc[2]), .stop_in_wait(siw), .stop_in_freeze(sif),
    .channel_0_out(ch[0]), .channel_1_out(ch[1]), .channel_2_out(ch[2]),
    .channel_3_out(ch[3]), .channel_4_out(ch[4]), .channel_5_out(ch[5]));

  always #2.5 clock = ~clock;

  // ===================================================================
  // helpers
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask

  function automatic int mr(int o);
    if (o == 0 || o == 1 || o == 3) return o == 0 ? g : (o == 1 ? p : c3);
    if (o >= 16 && o < 28) return o[0] ? v[(o-16)/2] & 255 : v[(o-16)/2] >> 8;
    if (o >= 32 && o < 56) return t[o-32];
    return 0;
  endfunction

  // ===================================================================
  // register port tasks: bw updates the model, br checks a read against it
  task bw(int o, int d);
    int i;
    @(posedge clock);
    wr <= 1'b1;
    addr <= BASE + 16'(o);
    wdata <= 8'(d);
    @(posedge clock);
    wr <= 1'b0;
    if (o == 0) g = g[7] ? g | (d & 192) : (g & 192) | d;
    if (o == 1 && !g[7]) p = d & 191;
    if (o == 3) c3 = p[7] ? d & 223 : (c3 & 31) | (d & 192);
    if (o >= 16 && o < 28) begin
      i = (o - 16) / 2;
      v[i] = o[0] ? (v[i] & 65280) | d : (v[i] & 255) | (d << 8);
      for (int k = 1; k < 6; k++)
        if (i == 0 && (c3[4:3] == 1 || (c3[4:3] == 2 && k < 4))) v[k] = v[0];
    end
    if (o >= 32 && o < 56 && (o < 40 || g[6])) t[o-32] = d;
  endtask

  task br(int o);
    @(posedge clock);
    rd <= 1'b1;
    addr <= BASE + 16'(o);
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, mr(o));
  endtask

  task co;
    int c, tp, bt;
    repeat (3) @(posedge clock);
    #1 chk({wl, mts, sp, acc, vlm, xc}, {g[7:6], g[2:0], p[7], c3[4:0]});
    chk(inv, p[5:0]);
    chk({siw, sif}, c3[7:6]);
    chk(ed, g[6] ? g[5:3] : {3{g[3]}});
    for (int q = 0; q < 3; q++) begin
      c = (q == 0 || !g[6]) ? cn[0] : cn[q];
      tp = c <= v[2*q];
      bt = g[q] ? c <= v[2*q+1] : !tp;
      if (!g[q] && c3[q]) {tp, bt} = {bt, tp};
      chk({ch[2*q+1], ch[2*q]}, {bt[0] ^ p[2*q+1], tp[0] ^ p[2*q]});
    end
  endtask

  // ===================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    for (int o = 0; o < 64; o++) br(o);
    bw(1, 128);
    for (int m = 0; m < 4; m++) begin
      bw(3, m * 8);
      for (int o = 27; o > 15; o--) begin
        lf = nx(lf);
        bw(o, lf[7:0]);
      end
      for (int o = 16; o < 28; o++) br(o);
    end
    for (int n = 0; n < 24; n++) begin
      lf = nx(lf);
      bw(0, lf[5:0] | (n == 12 ? 64 : 0));
      bw(1, lf[13:6]);
      bw(3, lf[23:16]);
      bw(16 + lf[27:24] % 12, lf[31:24]);
      bw(32 + n, lf[7:0]);
      br(32 + n);
      @(posedge clock);
      cn[0] <= lf[14:0];
      cn[1] <= lf[29:15];
      cn[2] <= ~lf[14:0];
      co;
      br(0);
      br(1);
      br(3);
      if (n == 16) bw(0, 128);
    end
    // a write strobe to offset 3 while ce is low must leave that register untouched
    @(posedge clock);
    ce <= 1'b0;
    wr <= 1'b1;
    addr <= BASE + 16'h0003;
    wdata <= 8'(c3 ^ 192);
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
    ce <= 1'b1;
    br(3);
    summarize;
  end

  initial begin
    #20000;
    n_mismatch++;
    summarize;
  end
endmodule // tb
